// ===== logic/jtbs_defs.vh
// Constants for the boundary-scan test access port
// Summary of operation
// - Four test inputs, one serial data output
// - Sixteen-state controller stepped by test clock, select
// - Power-on reset forces Test-Logic-Reset state
// - Test lines held inactive during bus cycles
// - Five-bit master/slave instruction register, latched outputs
// - Instruction shifts MSB-in, LSB-out per rising edge
// - New instruction latches; previous actions end
// - Latched instruction plus state select data register
// - Instruction capture loads fixed pattern 1101
// - Test reset loads identification instruction immediately
// - New opcode becomes active on falling edge
// - Opcode 00000 places boundary register in path
// - External test drives pins, changing on falling edge
// - External test captures input pins on rising edge
// - Opcode 0001 samples pins without disturbing operation
// - Sampling moves master cells to slaves falling
// - Opcode 00010 clamps pins, bypass in path
// - Opcode 11111 selects one-bit bypass register
// - Boundary chain covers all non-test pins
// - Select high five clocks returns to reset
// - Data registers shift toward output, no inversion
`ifndef JTBS_DEFS_VH
`define JTBS_DEFS_VH

`define JTBS_IR_W 5
`define JTBS_ST_W 4
`define JTBS_BSR_LEN 8
`define JTBS_OUT_MASK 8'hf0

`define JTBS_IR_CAPTURE 5'h0d
`define JTBS_OP_EXTEST 5'h00
`define JTBS_OP_SAMPLE 5'h01
`define JTBS_OP_INTERNAL_SCAN_ENABLE_INSTR 5'h02
`define JTBS_OP_BYPASS 5'h1f
`define JTBS_OP_IDCODE 5'h03

`define JTBS_ST_TLR 4'hf
`define JTBS_ST_RTI 4'hc
`define JTBS_ST_SEL_DR 4'h7
`define JTBS_ST_CAP_DR 4'h6
`define JTBS_ST_SH_DR 4'h2
`define JTBS_ST_EX1_DR 4'h1
`define JTBS_ST_PAU_DR 4'h3
`define JTBS_ST_EX2_DR 4'h0
`define JTBS_ST_UPD_DR 4'h5
`define JTBS_ST_SEL_IR 4'h4
`define JTBS_ST_CAP_IR 4'he
`define JTBS_ST_SH_IR 4'ha
`define JTBS_ST_EX1_IR 4'h9
`define JTBS_ST_PAU_IR 4'hb
`define JTBS_ST_EX2_IR 4'h8
`define JTBS_ST_UPD_IR 4'hd

`endif

// ===== logic/jtbs_bsr_cell.v
// One boundary-scan cell: capture/shift master and update slave
module jtbs_bsr_cell (
    input wire clk_sys_i, // System clock
    input wire sys_rst_i, // Synchronous reset, active high
    input wire capture_i, // Parallel load pulse
    input wire shift_i, // Shift pulse
    input wire update_i, // Master to slave pulse
    input wire par_i, // Parallel capture value
    input wire ser_i, // Serial input from upstream cell
    output reg ser_o, // Master stage, serial out
    output reg upd_o // Slave stage
);
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ser_o <= 1'b0;
        end else if (capture_i) begin
            ser_o <= par_i;
        end else if (shift_i) begin
            ser_o <= ser_i;
        end
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            upd_o <= 1'b0;
        end else if (update_i) begin
            upd_o <= ser_o;
        end
    end
endmodule

// ===== logic/jtbs_tap.v
// Boundary-scan test access port with controller, instruction and data registers
`include "jtbs_defs.vh"

module jtbs_tap #(
    parameter BSR_LEN = `JTBS_BSR_LEN,
    parameter [BSR_LEN-1:0] OUT_MASK = `JTBS_OUT_MASK
) (
    input wire clk_sys_i, // System clock, 250 MHz
    input wire sys_rst_i, // Power-on reset, synchronous, active high
    input wire tck_i, // Test clock pin
    input wire tms_i, // Test mode select pin
    input wire tdi_i, // Test serial data in pin
    input wire trst_n_i, // Test reset pin, active low
    output reg tdo_o, // Test serial data out
    output reg tdo_oe_o, // Test data out drive enable
    input wire bus_busy_i, // Bridge bus logic running a cycle
    input wire [BSR_LEN-1:0] sys_out_i, // Values core logic drives to pins
    input wire [BSR_LEN-1:0] pin_in_i, // Levels seen at pins
    output reg [BSR_LEN-1:0] pin_o, // Values driven to pins
    output reg pin_test_o, // Pins driven from boundary register
    output reg internal_scan_enable_instr, // Internal scan code active
    output reg [`JTBS_ST_W-1:0] tap_state_o, // Controller state
    output reg [`JTBS_IR_W-1:0] instr_o // Active instruction
);
    // Test clock: two synchroniser flops, third flop only for edge detection
    reg tck_m;
    reg tck_s;
    reg tck_d;

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            tck_m <= 1'b0;
            tck_s <= 1'b0;
            tck_d <= 1'b0;
        end else begin
            tck_m <= tck_i;
            tck_s <= tck_m;
            tck_d <= tck_s;
        end
    end

    // Mode select and serial data, idle high
    reg tms_m;
    reg tms_s;
    reg tdi_m;
    reg tdi_s;

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            tms_m <= 1'b1;
            tms_s <= 1'b1;
            tdi_m <= 1'b1;
            tdi_s <= 1'b1;
        end else begin
            tms_m <= tms_i;
            tms_s <= tms_m;
            tdi_m <= tdi_i;
            tdi_s <= tdi_m;
        end
    end

    // Test reset, held inactive through power-on reset
    reg trst_m;
    reg trst_s;

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            trst_m <= 1'b1;
            trst_s <= 1'b1;
        end else begin
            trst_m <= trst_n_i;
            trst_s <= trst_m;
        end
    end

    // Pin levels for boundary capture
    reg [BSR_LEN-1:0] pin_m;
    reg [BSR_LEN-1:0] pin_s;

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pin_m <= {BSR_LEN{1'b0}};
            pin_s <= {BSR_LEN{1'b0}};
        end else begin
            pin_m <= pin_in_i;
            pin_s <= pin_m;
        end
    end

    wire tck_rise = tck_s & ~tck_d;
    wire tck_fall = ~tck_s & tck_d;
    wire tap_reset = sys_rst_i | ~trst_s;

    // Controller
    reg [`JTBS_ST_W-1:0] state;
    reg [`JTBS_ST_W-1:0] next_state;

    always @* begin
        case (state)
            `JTBS_ST_TLR: begin
                next_state = tms_s ? `JTBS_ST_TLR : `JTBS_ST_RTI;
            end
            `JTBS_ST_RTI: begin
                next_state = tms_s ? `JTBS_ST_SEL_DR : `JTBS_ST_RTI;
            end
            `JTBS_ST_SEL_DR: begin
                next_state = tms_s ? `JTBS_ST_SEL_IR : `JTBS_ST_CAP_DR;
            end
            `JTBS_ST_CAP_DR: begin
                next_state = tms_s ? `JTBS_ST_EX1_DR : `JTBS_ST_SH_DR;
            end
            `JTBS_ST_SH_DR: begin
                next_state = tms_s ? `JTBS_ST_EX1_DR : `JTBS_ST_SH_DR;
            end
            `JTBS_ST_EX1_DR: begin
                next_state = tms_s ? `JTBS_ST_UPD_DR : `JTBS_ST_PAU_DR;
            end
            `JTBS_ST_PAU_DR: begin
                next_state = tms_s ? `JTBS_ST_EX2_DR : `JTBS_ST_PAU_DR;
            end
            `JTBS_ST_EX2_DR: begin
                next_state = tms_s ? `JTBS_ST_UPD_DR : `JTBS_ST_SH_DR;
            end
            `JTBS_ST_UPD_DR: begin
                next_state = tms_s ? `JTBS_ST_SEL_DR : `JTBS_ST_RTI;
            end
            `JTBS_ST_SEL_IR: begin
                next_state = tms_s ? `JTBS_ST_TLR : `JTBS_ST_CAP_IR;
            end
            `JTBS_ST_CAP_IR: begin
                next_state = tms_s ? `JTBS_ST_EX1_IR : `JTBS_ST_SH_IR;
            end
            `JTBS_ST_SH_IR: begin
                next_state = tms_s ? `JTBS_ST_EX1_IR : `JTBS_ST_SH_IR;
            end
            `JTBS_ST_EX1_IR: begin
                next_state = tms_s ? `JTBS_ST_UPD_IR : `JTBS_ST_PAU_IR;
            end
            `JTBS_ST_PAU_IR: begin
                next_state = tms_s ? `JTBS_ST_EX2_IR : `JTBS_ST_PAU_IR;
            end
            `JTBS_ST_EX2_IR: begin
                next_state = tms_s ? `JTBS_ST_UPD_IR : `JTBS_ST_SH_IR;
            end
            `JTBS_ST_UPD_IR: begin
                next_state = tms_s ? `JTBS_ST_SEL_DR : `JTBS_ST_RTI;
            end
            default: begin
                next_state = `JTBS_ST_TLR;
            end
        endcase
    end

    // Power-on or test reset forces Test-Logic-Reset at once
    always @(posedge clk_sys_i) begin
        if (tap_reset) begin
            state <= `JTBS_ST_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // Controller state decode
    wire in_tlr = (state == `JTBS_ST_TLR);
    wire in_cap_ir = (state == `JTBS_ST_CAP_IR);
    wire in_sh_ir = (state == `JTBS_ST_SH_IR);
    wire in_upd_ir = (state == `JTBS_ST_UPD_IR);
    wire in_cap_dr = (state == `JTBS_ST_CAP_DR);
    wire in_sh_dr = (state == `JTBS_ST_SH_DR);
    wire in_upd_dr = (state == `JTBS_ST_UPD_DR);

    // Instruction register
    reg [`JTBS_IR_W-1:0] instruction_shift_register;
    reg [`JTBS_IR_W-1:0] ir_active;

    always @(posedge clk_sys_i) begin
        if (tap_reset) begin
            instruction_shift_register <= `JTBS_IR_CAPTURE;
        end else if (tck_rise) begin
            if (in_cap_ir) begin
                instruction_shift_register <= `JTBS_IR_CAPTURE;
            end else if (in_sh_ir) begin
                instruction_shift_register <=
                    {tdi_s, instruction_shift_register[`JTBS_IR_W-1:1]};
            end
        end
    end

    // Slave stage: loads on the falling edge in Update-IR
    always @(posedge clk_sys_i) begin
        if (tap_reset) begin
            ir_active <= `JTBS_OP_IDCODE;
        end else if (in_tlr) begin
            ir_active <= `JTBS_OP_IDCODE;
        end else if (tck_fall && in_upd_ir) begin
            ir_active <= instruction_shift_register;
        end
    end

    // Instruction decode; all other codes act as bypass
    wire op_extest = (ir_active == `JTBS_OP_EXTEST);
    wire op_sample = (ir_active == `JTBS_OP_SAMPLE);
    wire op_clamp = (ir_active == `JTBS_OP_INTERNAL_SCAN_ENABLE_INSTR);
    wire op_bypass = (ir_active == `JTBS_OP_BYPASS);
    // Reset id code and every unlisted code fall back to bypass
    wire op_other = ~(op_extest | op_sample | op_clamp | op_bypass);
    wire sel_bsr = op_extest | op_sample;
    wire sel_bypass = op_bypass | op_clamp | op_other;

    // Bypass register
    reg bypass_bit;

    always @(posedge clk_sys_i) begin
        if (tap_reset) begin
            bypass_bit <= 1'b0;
        end else if (tck_rise && sel_bypass) begin
            if (in_cap_dr) begin
                bypass_bit <= 1'b0;
            end else if (in_sh_dr) begin
                bypass_bit <= tdi_s;
            end
        end
    end

    // Boundary-scan register, one cell per pin
    wire bsr_cap = tck_rise & sel_bsr & in_cap_dr;
    wire bsr_shift = tck_rise & sel_bsr & in_sh_dr;
    wire bsr_upd = tck_fall & sel_bsr & in_upd_dr;
    wire [BSR_LEN-1:0] bsr_ser;
    wire [BSR_LEN-1:0] bsr_slave;

    genvar i;
    generate
        for (i = 0; i < BSR_LEN; i = i + 1) begin : g_cell
            // Output cells sample the driven value under sampling
            wire cap_val = (op_sample && OUT_MASK[i]) ? sys_out_i[i] : pin_s[i];
            wire ser_in = (i == BSR_LEN - 1) ? tdi_s : bsr_ser[(i + 1) % BSR_LEN];
            jtbs_bsr_cell u_cell (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(tap_reset),
                .capture_i(bsr_cap),
                .shift_i(bsr_shift),
                .update_i(bsr_upd),
                .par_i(cap_val),
                .ser_i(ser_in),
                .ser_o(bsr_ser[i]),
                .upd_o(bsr_slave[i])
            );
        end
    endgenerate

    // Serial output changes on the falling test-clock edge
    wire shifting = in_sh_ir | in_sh_dr;

    always @(posedge clk_sys_i) begin
        if (tap_reset) begin
            tdo_o <= 1'b0;
        end else if (tck_fall) begin
            if (in_sh_ir) begin
                tdo_o <= instruction_shift_register[0];
            end else if (in_sh_dr) begin
                tdo_o <= sel_bsr ? bsr_ser[0] : bypass_bit;
            end
        end
    end

    // Drive enable dropped at once while the bus is busy
    always @(posedge clk_sys_i) begin
        if (tap_reset) begin
            tdo_oe_o <= 1'b0;
        end else if (bus_busy_i) begin
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_o <= shifting;
        end
    end

    // Pin multiplexer: test values under external test or clamp
    wire test_drive = (op_extest | op_clamp) & ~bus_busy_i;

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pin_o <= {BSR_LEN{1'b0}};
            pin_test_o <= 1'b0;
        end else begin
            pin_o <= test_drive ? bsr_slave : sys_out_i;
            pin_test_o <= test_drive;
        end
    end

    // Status outputs
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            internal_scan_enable_instr <= 1'b0;
            tap_state_o <= `JTBS_ST_TLR;
            instr_o <= `JTBS_OP_IDCODE;
        end else begin
            internal_scan_enable_instr <= op_clamp;
            tap_state_o <= state;
            instr_o <= ir_active;
        end
    end
endmodule

// ===== tb/jtbs_tap_monitor.sv
// Checker for the boundary-scan test access port
`include "jtbs_defs.vh"
module jtbs_tap_monitor #(
    parameter BSR_LEN = 8,
    parameter [BSR_LEN-1:0] OUT_MASK = 8'hf0
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    input wire trst_n_i,
    input wire tdo_o,
    input wire tdo_oe_o,
    input wire bus_busy_i,
    input wire [BSR_LEN-1:0] sys_out_i,
    input wire [BSR_LEN-1:0] pin_in_i,
    input wire [BSR_LEN-1:0] pin_o,
    input wire pin_test_o,
    input wire internal_scan_enable_instr,
    input wire [`JTBS_ST_W-1:0] tap_state_o,
    input wire [`JTBS_IR_W-1:0] instr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_trst_held; !trst_n_i [*6]; endsequence
    sequence s_busy_held; bus_busy_i [*3]; endsequence
    property p_por;
        disable iff (1'b0) sys_rst_i |=> tap_state_o == `JTBS_ST_TLR && instr_o == `JTBS_OP_IDCODE;
    endproperty
    a_por: assert property (p_por) else $error("state not reset");
    property p_trst; s_trst_held |=> tap_state_o == `JTBS_ST_TLR && instr_o == `JTBS_OP_IDCODE;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset ignored");
    property p_busy_oe; bus_busy_i |=> !tdo_oe_o; endproperty
    a_busy_oe: assert property (p_busy_oe) else $error("drive while busy");
    property p_busy_pin; s_busy_held |=> pin_o == $past(sys_out_i); endproperty
    a_busy_pin: assert property (p_busy_pin) else $error("pins overridden while busy");
    property p_oe_shift; tdo_oe_o |-> tap_state_o inside {`JTBS_ST_SH_IR, `JTBS_ST_SH_DR,
        `JTBS_ST_EX1_IR, `JTBS_ST_EX1_DR}; endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("drive outside shift");
    property p_state_hold; (!tck_i && trst_n_i) [*8] |-> $stable(tap_state_o); endproperty
    a_state_hold: assert property (p_state_hold) else $error("state moved without clock");
    property p_scan_flag; $stable(instr_o) [*3] |->
        internal_scan_enable_instr == (instr_o == `JTBS_OP_INTERNAL_SCAN_ENABLE_INSTR); endproperty
    a_scan_flag: assert property (p_scan_flag) else $error("scan flag wrong");
    property p_pin_src; pin_test_o == ((instr_o inside {`JTBS_OP_EXTEST, `JTBS_OP_INTERNAL_SCAN_ENABLE_INSTR})
        && !$past(bus_busy_i)); endproperty
    a_pin_src: assert property (p_pin_src) else $error("pins driven by wrong code");
endmodule

// ===== tb/jtbs_jtag_master.sv
// Model of the external test master
module jtbs_jtag_master (
    input wire clk_i, // Bench clock
    input wire tdo_i, // Resolved serial data line
    output logic tck_o, // Test clock, still between frames
    output logic tms_o, // Mode select
    output logic tdi_o, // Serial data
    output logic trst_n_o // Test reset, active low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic b;
    initial begin
        tck_o = 0;
        tms_o = 1;
        tdi_o = 0;
        trst_n_o = 1;
    end
    // One 32 ns test clock period; tdo taken late in the high phase
    task step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #16 tck_o = 1;
        #12 tdo = tdo_i;
        #4 tck_o = 0;
    endtask
    task walk(input logic [7:0] tv, input int n);
        @(negedge clk_i);
        for (int i = 0; i < n; i++) step(tv[i], 1'b0, b);
    endtask
    task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 0;
        @(negedge clk_i);
        step(1, 0, b);
        if (ir) step(1, 0, b);
        step(0, 0, b);
        step(0, 0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1, 0, b);
        step(0, 0, b);
    endtask
    task pulse_trst();
        @(negedge clk_i);
        trst_n_o = 0;
        #40 trst_n_o = 1;
    endtask
endmodule

// ===== tb/test_jtbs_tap.sv
// Self-checking bench for the boundary-scan test access port
`include "jtbs_defs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s: expected %h seen %h", nm, e, g); end end
module test_jtbs_tap;
    timeunit 1ns;
    timeprecision 1ps;
    localparam BSR_LEN = 8;
    localparam [7:0] OUT_MASK = 8'hf0;
    logic clk_sys_i = 0, sys_rst_i = 1, bus_busy_i = 0;
    logic [7:0] sys_out_i = 0, pin_in_i = 0, pat;
    wire tck_i, tms_i, tdi_i, trst_n_i, tdo_o, tdo_oe_o, pin_test_o, internal_scan_enable_instr;
    wire [7:0] pin_o;
    wire [3:0] tap_state_o;
    wire [4:0] instr_o;
    wire tdo_w = tdo_oe_o ? tdo_o : 1'b1; // Pulled up when released
    int fail_count = 0, n_checks = 0;
    logic [31:0] dout, din;
    logic [4:0] op;
    jtbs_tap #(.BSR_LEN(BSR_LEN), .OUT_MASK(OUT_MASK)) jtbs_tap_i (.*);
    jtbs_jtag_master mst (.clk_i(clk_sys_i), .tdo_i(tdo_w), .tck_o(tck_i), .tms_o(tms_i),
        .tdi_o(tdi_i), .trst_n_o(trst_n_i));
    always #2 clk_sys_i = ~clk_sys_i;
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Reference register model: cells preloaded with cap, fed from the serial input
    function automatic logic [31:0] shift_model(input int len, input logic [31:0] cap,
        input int n, input logic [31:0] d);
        bit q[$];
        logic [31:0] r;
        r = 0;
        for (int i = 0; i < len; i++) q.push_back(cap[i]);
        for (int i = 0; i < n; i++) begin
            r[i] = q.pop_front();
            q.push_back(d[i]);
        end
        return r;
    endfunction
    task load(input logic [4:0] c);
        mst.scan(1, 5, {27'h0, c}, dout);
        `CHK("ir capture", 5'h0d, dout[4:0])
        repeat (4) @(negedge clk_sys_i);
        `CHK("instr", c, instr_o)
    endtask
    task dr(input int n, input logic [31:0] d, input logic [31:0] e, input string nm);
        logic [31:0] mk;
        mk = (32'h1 << n) - 1;
        mst.scan(0, n, d, dout);
        repeat (4) @(negedge clk_sys_i);
        `CHK(nm, e & mk, dout & mk)
    endtask
    initial begin
        void'($urandom(32'hbe38bbb6));
        repeat (20) @(negedge clk_sys_i);
        sys_rst_i = 0;
        repeat (10) @(negedge clk_sys_i);
        `CHK("por state", `JTBS_ST_TLR, tap_state_o)
        `CHK("por instr", `JTBS_OP_IDCODE, instr_o)
        mst.walk(8'h00, 1);
        din = $urandom;
        dr(16, din, shift_model(1, 0, 16, din), "id bypass");
        $display("done reset");
        sys_out_i = $urandom;
        pin_in_i = $urandom;
        load(`JTBS_OP_SAMPLE);
        din = $urandom;
        pat = (sys_out_i & OUT_MASK) | (pin_in_i & ~OUT_MASK);
        dr(8, din, shift_model(8, pat, 8, din), "sample");
        pat = din[7:0];
        `CHK("sample pins", sys_out_i, pin_o)
        load(`JTBS_OP_EXTEST);
        `CHK("preload pins", pat, pin_o)
        `CHK("pin test", 1'b1, pin_test_o)
        pin_in_i = $urandom;
        din = $urandom;
        dr(8, din, shift_model(8, pin_in_i, 8, din), "extest");
        pat = din[7:0];
        `CHK("extest pins", pat, pin_o)
        $display("done extest");
        load(`JTBS_OP_INTERNAL_SCAN_ENABLE_INSTR);
        `CHK("scan flag", 1'b1, internal_scan_enable_instr)
        dr(8, din + 32'h5a, shift_model(1, 0, 8, din + 32'h5a), "clamp path");
        `CHK("clamp pins", pat, pin_o)
        load(`JTBS_OP_BYPASS);
        `CHK("bypass test", 1'b0, pin_test_o)
        `CHK("bypass pins", sys_out_i, pin_o)
        dr(12, din, shift_model(1, 0, 12, din), "bypass");
        repeat (3) begin
            op = $urandom_range(3, 30);
            load(op);
            dr(4, din, shift_model(1, 0, 4, din), "unlisted");
        end
        $display("done bypass");
        load(`JTBS_OP_EXTEST);
        bus_busy_i = 1;
        repeat (3) @(negedge clk_sys_i);
        `CHK("busy pins", sys_out_i, pin_o)
        dr(8, din, 32'hff, "busy line");
        `CHK("busy oe", 1'b0, tdo_oe_o)
        bus_busy_i = 0;
        $display("done busy");
        mst.walk(8'h01, 3);
        mst.walk(8'h1f, 5);
        repeat (10) @(negedge clk_sys_i);
        `CHK("tms reset", `JTBS_ST_TLR, tap_state_o)
        `CHK("tms instr", `JTBS_OP_IDCODE, instr_o)
        mst.walk(8'h00, 1);
        load(`JTBS_OP_EXTEST);
        mst.pulse_trst();
        repeat (10) @(negedge clk_sys_i);
        `CHK("trst state", `JTBS_ST_TLR, tap_state_o)
        `CHK("trst instr", `JTBS_OP_IDCODE, instr_o)
        `CHK("trst pins", 1'b0, pin_test_o)
        $display("done trst");
        final_report;
    end
    initial begin
        #100000;
        fail_count++;
        final_report;
    end
endmodule
bind jtbs_tap jtbs_tap_monitor #(.BSR_LEN(BSR_LEN), .OUT_MASK(OUT_MASK)) jtbs_tap_monitor_i (.*);
